// file: include/bitstream_modulator_defines.vh
`ifndef BITSTREAM_MODULATOR_DEFINES_VH
`define BITSTREAM_MODULATOR_DEFINES_VH

// clock figures
`define CLK_FREQ_MHZ      40
`define POR_WAIT_US       600
`define POR_WAIT_CYCLES   (`POR_WAIT_US * `CLK_FREQ_MHZ)

// channel layout
`define NUM_CHANNELS      4
`define CODE_WIDTH        13
`define SAMPLE_WIDTH      52
`define ACC_WIDTH         24

// input scaling, millivolts
`define FSR_MV            24'sd2500
`define LINEAR_MV         24'sd2000
`define INPUT_GAIN        3
`define FB_LEVEL          24'sd10000

// clock source select levels
`define SRC_INTERNAL      1'b1
`define SRC_EXTERNAL      1'b0

// buffer shape
`define BUF_DEPTH         2
`define BUF_PTR_WIDTH     1
`define BUF_CNT_WIDTH     2

`endif

// file: verif/bitstream_modulator_assertions.sv
`timescale 1ns/100ps
module bitstream_modulator_checker
#(
  parameter POR_WAIT_CYCLES = 8
)
(
  input wire        clk_in,                       // clock
  input wire        srst_in,                      // sync reset
  input wire        clock_source_select_in,       // source pin
  input wire        external_clock_input_in,      // ext clock pin
  input wire [51:0] sample_data_in,               // codes
  input wire        sample_valid_in,              // word offered
  input wire        sample_ready_out,             // room
  input wire        modulator_clock_output_out,   // mod clock
  input wire [3:0]  channel_bitstream_output_out, // bits
  input wire [3:0]  channel_overrange_out,        // overrange
  input wire        source_internal_out,          // synced select
  input wire        device_ready_out              // wait done
);
  reg [15:0] since_reg;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // edges since reset release
  always @(posedge clk_in)
    since_reg <= srst_in ? 16'h0000 : since_reg + 16'h0001;
  a_bits_on_fall: assert property ($changed(channel_bitstream_output_out)
    |-> $fell(modulator_clock_output_out)) else $error("bits moved off falling edge");
  a_high_two: assert property ($rose(modulator_clock_output_out) && source_internal_out
    |=> modulator_clock_output_out ##1 (!modulator_clock_output_out || !source_internal_out))
    else $error("modulator clock high time wrong");
  a_low_two: assert property ($fell(modulator_clock_output_out) && source_internal_out
    |=> !modulator_clock_output_out ##1 (modulator_clock_output_out || !source_internal_out))
    else $error("modulator clock low time wrong");
  a_quiet_wait: assert property (!device_ready_out |-> !modulator_clock_output_out
    && channel_bitstream_output_out == 4'h0) else $error("activity before ready");
  a_ready_holds: assert property (device_ready_out |=> device_ready_out)
    else $error("ready dropped");
  a_ready_time: assert property ($rose(device_ready_out) |-> since_reg >= POR_WAIT_CYCLES - 1
    && since_reg <= POR_WAIT_CYCLES + 1) else $error("ready at wrong time");
  a_ext_static: assert property ((!clock_source_select_in && $stable(external_clock_input_in))[*8]
    |-> $stable(modulator_clock_output_out)) else $error("clock moved without ext edge");
  a_src_high: assert property (clock_source_select_in[*4] |-> source_internal_out)
    else $error("select high not followed");
  a_src_low: assert property (!clock_source_select_in[*4] |-> !source_internal_out)
    else $error("select low not followed");
  a_stall_cause: assert property ($fell(sample_ready_out) |-> $past(sample_valid_in))
    else $error("ready fell without a word");
endmodule
bind bitstream_modulator bitstream_modulator_checker
  #(.POR_WAIT_CYCLES(POR_WAIT_CYCLES)) bitstream_modulator_checker_inst (.*);

// file: verif/bitstream_modulator_tb_top.sv
`timescale 1ns/100ps
module bitstream_modulator_tb_top;
  reg         clk_in, srst_in, sel, ext, valid, clr, saw_full;
  reg  [51:0] data;
  wire        ready, mclk, src, dev_rdy;
  wire [3:0]  bits, ovr;
  wire [15:0] smp, wrd, s3, s2, sf, sc;
  wire [63:0] ones;
  integer     n_fail, tests_run, cyc, i;
  bitstream_modulator #(.POR_WAIT_CYCLES(8)) bitstream_modulator_inst (.clk_in(clk_in),
    .srst_in(srst_in), .clock_source_select_in(sel), .external_clock_input_in(ext),
    .sample_data_in(data), .sample_valid_in(valid), .sample_ready_out(ready),
    .modulator_clock_output_out(mclk), .channel_bitstream_output_out(bits),
    .channel_overrange_out(ovr), .source_internal_out(src), .device_ready_out(dev_rdy));
  decimation_receiver decimation_receiver_inst (.mod_clk_in(mclk), .bits_in(bits),
    .clear_in(clr), .samples_out(smp), .ones_out(ones), .words_out(wrd), .sinc3_out(s3),
    .sinc2_out(s2), .fast_out(sf), .cascade_out(sc));
  // clock and hang guard
  initial
  begin
    clk_in = 0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    cyc = cyc + 1;
    if (ready === 1'b0) saw_full = 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  end
  task step(input integer n);
    begin repeat (n) @(posedge clk_in); #2; end
  endtask
  task chk(input [8*8:1] nm, input [31:0] lo, input [31:0] hi, input [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (^g === 1'bx || g < lo || g > hi)
      begin
        n_fail = n_fail + 1;
        $display("FAIL %0s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
    end
  endtask
  task window(input integer n);
    begin clr = 1; step(1); clr = 0; step(n); end
  endtask
  task t_por;
    begin
      chk("early", 0, 0, {31'h0, dev_rdy});
      for (i = 0; i < 20 && dev_rdy !== 1'b1; i = i + 1) step(1);
      chk("wait", 7, 9, i);
      window(40);
      chk("rate", 10, 10, smp);
    end
  endtask
  task t_dens(input [12:0] code, input [15:0] lo, input [15:0] hi, input [3:0] o,
    input integer p);
    begin
      data = {4{code}};
      valid = 1;
      step(20);
      saw_full = 0;
      window(800);
      for (i = 0; i < 4; i = i + 1) chk("density", lo, hi, ones[16*i+:16]);
      chk("stall", 1, 1, {31'h0, saw_full});
      chk("overrng", o, o, {28'h0, ovr});
      chk("words", 12, 12, {16'h0, wrd});
      chk("sinc3", 4096 * p / 1000 - 410, 4096 * p / 1000 + 410, {16'h0, s3});
      chk("sinc2", 256 * p / 1000 - 26, 256 * p / 1000 + 26, {16'h0, s2});
      chk("fast", 512 * p / 1000 - 52, 512 * p / 1000 + 52, {16'h0, sf});
      chk("cascade", 32768 * p / 1000 - 3277, 32768 * p / 1000 + 3277, {16'h0, sc});
    end
  endtask
  task t_ext;
    begin
      valid = 0;
      step(12);
      chk("drained", 1, 1, {31'h0, ready});
      sel = 0;
      step(20);
      window(40);
      chk("extidle", 0, 0, smp);
      repeat (10) begin ext = 1; step(4); ext = 0; step(4); end
      step(8);
      chk("extrate", 4, 5, smp);
      sel = 1;
      step(20);
      chk("src", 1, 1, {31'h0, src});
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // reset, then the scenarios
  initial
  begin
    n_fail = 0; tests_run = 0; cyc = 0; saw_full = 0;
    srst_in = 1; sel = 1; ext = 0; valid = 0; clr = 0; data = 52'h0;
    step(10);
    srst_in = 0;
    t_por;
    t_dens(13'h0000, 16'd92, 16'd108, 4'h0, 500);
    t_dens(13'h07D0, 16'd152, 16'd168, 4'h0, 800);
    t_dens(13'h1830, 16'd32, 16'd48, 4'h0, 200);
    t_dens(13'h0960, 16'd160, 16'd190, 4'hF, 860);
    step(8);
    t_ext;
    report_and_stop;
  end
endmodule

// file: verif/decimation_receiver.sv
`timescale 1ns/100ps
module decimation_receiver
#(
  parameter OVERSAMPLING_RATIO = 16 // low end of the sinc3 range keeps runs short
)
(
  input  wire        mod_clk_in,  // shared modulator clock
  input  wire [3:0]  bits_in,     // channel bitstreams
  input  wire        clear_in,    // restart window and filters
  output reg  [15:0] samples_out, // samples taken
  output reg  [63:0] ones_out,    // ones per channel
  output reg  [15:0] words_out,   // decimated words made
  output reg  [15:0] sinc3_out,   // channel 0 third-order word
  output reg  [15:0] sinc2_out,   // channel 0 second-order word
  output reg  [15:0] fast_out,    // channel 0 fast-settling word
  output reg  [15:0] cascade_out  // channel 0 two-stage word
);
  reg [15:0] a1, a2, a3, a2_d, a3_d, c1, c1_d, c2, c2_d, e1, e1_d;
  reg [15:0] f_d1, f_d2, w1, w2, w3;
  integer    i, phase;
  // one sample per period on the rising edge, ones summed, channel 0 decimated
  always @(posedge mod_clk_in or posedge clear_in)
  begin
    if (clear_in)
    begin
      samples_out <= 16'h0000;
      ones_out    <= 64'h0;
      words_out   <= 16'h0000;
      sinc3_out   <= 16'h0000;
      sinc2_out   <= 16'h0000;
      fast_out    <= 16'h0000;
      cascade_out <= 16'h0000;
      a1          <= 16'h0000;
      a2          <= 16'h0000;
      a3          <= 16'h0000;
      a2_d        <= 16'h0000;
      a3_d        <= 16'h0000;
      c1          <= 16'h0000;
      c1_d        <= 16'h0000;
      c2          <= 16'h0000;
      c2_d        <= 16'h0000;
      e1          <= 16'h0000;
      e1_d        <= 16'h0000;
      f_d1        <= 16'h0000;
      f_d2        <= 16'h0000;
      w1          <= 16'h0000;
      w2          <= 16'h0000;
      w3          <= 16'h0000;
      phase       <= 0;
    end
    else
    begin
      samples_out <= samples_out + 16'h0001;
      for (i = 0; i < 4; i = i + 1)
        ones_out[16*i+:16] <= ones_out[16*i+:16] + bits_in[i];
      // modular integrators at the modulator rate
      a1 <= a1 + bits_in[0];
      a2 <= a2 + a1;
      a3 <= a3 + a2;
      if (phase == OVERSAMPLING_RATIO - 1)
      begin
        phase     <= 0;
        words_out <= words_out + 16'h0001;
        // third-order combs at the data clock
        c1        <= a3 - a3_d;
        a3_d      <= a3;
        c2        <= c1 - c1_d;
        c1_d      <= c1;
        sinc3_out <= c2 - c2_d;
        c2_d      <= c2;
        // second-order path for fast overcurrent words
        e1        <= a2 - a2_d;
        a2_d      <= a2;
        sinc2_out <= e1 - e1_d;
        e1_d      <= e1;
        // second-order word plus itself two words back
        fast_out  <= sinc2_out + f_d2;
        f_d1      <= sinc2_out;
        f_d2      <= f_d1;
        // third-order smoothing of the sinc3 words as a second stage
        cascade_out <= sinc3_out + 16'd3 * w1 + 16'd3 * w2 + w3;
        w1          <= sinc3_out;
        w2          <= w1;
        w3          <= w2;
      end
      else
        phase <= phase + 1;
    end
  end
endmodule

// file: verilog/bitstream_modulator.v
`timescale 1ns/100ps
`include "bitstream_modulator_defines.vh"

module bitstream_modulator
#(
  parameter POR_WAIT_CYCLES = `POR_WAIT_CYCLES
)
(
  input  wire                     clk_in,                       // 40 MHz clock
  input  wire                     srst_in,                      // sync reset, active high
  input  wire                     clock_source_select_in,       // pin: 1 internal, 0 external
  input  wire                     external_clock_input_in,      // pin: external system clock
  input  wire [`SAMPLE_WIDTH-1:0] sample_data_in,               // four signed mV codes
  input  wire                     sample_valid_in,              // sample word offered
  output wire                     sample_ready_out,             // buffer can take word
  output wire                     modulator_clock_output_out,   // shared modulator clock
  output wire [3:0]               channel_bitstream_output_out, // one bit per channel
  output wire [3:0]               channel_overrange_out,        // input beyond linear span
  output wire                     source_internal_out,          // synced select level
  output wire                     device_ready_out              // power-on wait complete
);

  reg                     sel_meta_reg;
  reg                     sel_sync_reg;
  reg                     ext_meta_reg;
  reg                     ext_sync_reg;
  reg                     ext_prev_reg;
  reg                     int_phase_reg;
  reg                     modclk_reg;
  reg  [3:0]              bits_reg;
  reg  [3:0]              overrange_reg;
  reg                     ready_reg;
  reg  [31:0]             por_count_reg;
  reg  [`SAMPLE_WIDTH-1:0] hold_reg;
  reg  [`NUM_CHANNELS*`ACC_WIDTH-1:0] int1_reg;
  reg  [`NUM_CHANNELS*`ACC_WIDTH-1:0] int2_reg;
  reg  [`NUM_CHANNELS*`ACC_WIDTH-1:0] int1_vec_next;
  reg  [`NUM_CHANNELS*`ACC_WIDTH-1:0] int2_vec_next;
  reg  [3:0]              bits_next;
  reg  [3:0]              overrange_next;
  reg  signed [`ACC_WIDTH-1:0] int1_next;
  reg  signed [`ACC_WIDTH-1:0] fb_next;
  reg  signed [`ACC_WIDTH-1:0] u_next;
  wire                    ext_rise;
  wire                    sys_tick;
  wire                    step;
  wire [`SAMPLE_WIDTH-1:0] buf_data;
  wire                    buf_valid;
  wire [`SAMPLE_WIDTH-1:0] cur_sample;
  integer                 j;

  // clamp a millivolt code to full scale and apply input gain
  function signed [`ACC_WIDTH-1:0] scale_input;
    input [`CODE_WIDTH-1:0] code;
    reg signed [`ACC_WIDTH-1:0] v;
    begin
      v = {{(`ACC_WIDTH-`CODE_WIDTH){code[`CODE_WIDTH-1]}}, code};
      if (v > `FSR_MV)
        v = `FSR_MV;
      else if (v < -`FSR_MV)
        v = -`FSR_MV;
      scale_input = v + v + v;
    end
  endfunction

  // true when a code lies outside the linear +-2 V span
  function beyond_linear;
    input [`CODE_WIDTH-1:0] code;
    reg signed [`ACC_WIDTH-1:0] v;
    begin
      v = {{(`ACC_WIDTH-`CODE_WIDTH){code[`CODE_WIDTH-1]}}, code};
      beyond_linear = (v > `LINEAR_MV) || (v < -`LINEAR_MV);
    end
  endfunction

  // two-stage synchronisers for both pins
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      sel_meta_reg <= `SRC_INTERNAL;
      sel_sync_reg <= `SRC_INTERNAL;
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      sel_meta_reg <= clock_source_select_in;
      sel_sync_reg <= sel_meta_reg;
      ext_meta_reg <= external_clock_input_in;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  assign ext_rise = ext_sync_reg & ~ext_prev_reg;

  // system clock tick: internal 20 MHz or external rising edge
  assign sys_tick = (sel_sync_reg == `SRC_INTERNAL) ? int_phase_reg : ext_rise;

  // modulator steps when its clock falls, so bits settle before the rise
  assign step = ready_reg & sys_tick & modclk_reg;

  // power-on wait before the outputs start
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      por_count_reg <= 32'h00000000;
      ready_reg     <= 1'b0;
    end
    else if (!ready_reg)
    begin
      if (por_count_reg >= POR_WAIT_CYCLES - 1)
        ready_reg <= 1'b1;
      else
        por_count_reg <= por_count_reg + 32'h00000001;
    end
  end

  // internal source and divide-by-two modulator clock
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      int_phase_reg <= 1'b0;
      modclk_reg    <= 1'b0;
    end
    else
    begin
      int_phase_reg <= ~int_phase_reg;
      if (ready_reg & sys_tick)
        modclk_reg <= ~modclk_reg;
    end
  end

  // input samples pass a two-entry buffer
  sample_buffer
  #(
    .WIDTH (`SAMPLE_WIDTH),
    .DEPTH (`BUF_DEPTH)
  )
  u_sample_buffer
  (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .in_data_in    (sample_data_in),
    .in_valid_in   (sample_valid_in),
    .in_ready_out  (sample_ready_out),
    .out_data_out  (buf_data),
    .out_valid_out (buf_valid),
    .out_ready_in  (step)
  );

  // fresh word if one waits, else last held word
  assign cur_sample = buf_valid ? buf_data : hold_reg;

  always @(posedge clk_in)
  begin
    if (srst_in)
      hold_reg <= {`SAMPLE_WIDTH{1'b0}};
    else if (step & buf_valid)
      hold_reg <= buf_data;
  end

  // second-order loop per channel, density 0.5 + 0.15 per volt;
  // bit taken from the fresh second integrator, an older one would destabilise the loop
  always @*
  begin
    int1_vec_next  = int1_reg;
    int2_vec_next  = int2_reg;
    bits_next      = bits_reg;
    overrange_next = overrange_reg;
    u_next         = {`ACC_WIDTH{1'b0}};
    fb_next        = {`ACC_WIDTH{1'b0}};
    int1_next      = {`ACC_WIDTH{1'b0}};
    for (j = 0; j < `NUM_CHANNELS; j = j + 1)
    begin
      u_next    = scale_input(cur_sample[j*`CODE_WIDTH +: `CODE_WIDTH]);
      fb_next   = bits_reg[j] ? `FB_LEVEL : -`FB_LEVEL;
      int1_next = $signed(int1_reg[j*`ACC_WIDTH +: `ACC_WIDTH]) + u_next - fb_next;
      int1_vec_next[j*`ACC_WIDTH +: `ACC_WIDTH] = int1_next;
      int2_vec_next[j*`ACC_WIDTH +: `ACC_WIDTH] =
        $signed(int2_reg[j*`ACC_WIDTH +: `ACC_WIDTH]) + int1_next - fb_next;
      bits_next[j]      = ~int2_vec_next[j*`ACC_WIDTH+`ACC_WIDTH-1];
      overrange_next[j] = beyond_linear(cur_sample[j*`CODE_WIDTH +: `CODE_WIDTH]);
    end
  end

  // loop state advances once per modulator step
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      bits_reg      <= 4'h0;
      overrange_reg <= 4'h0;
      int1_reg      <= {(`NUM_CHANNELS*`ACC_WIDTH){1'b0}};
      int2_reg      <= {(`NUM_CHANNELS*`ACC_WIDTH){1'b0}};
    end
    else if (step)
    begin
      int1_reg      <= int1_vec_next;
      int2_reg      <= int2_vec_next;
      bits_reg      <= bits_next;
      overrange_reg <= overrange_next;
    end
  end

  // shared clock plus per-channel bits
  assign modulator_clock_output_out   = modclk_reg;
  assign channel_bitstream_output_out = bits_reg;
  assign channel_overrange_out        = overrange_reg;
  assign source_internal_out          = sel_sync_reg;
  assign device_ready_out             = ready_reg;

endmodule

// file: verilog/sample_buffer.v
`timescale 1ns/100ps
`include "bitstream_modulator_defines.vh"

module sample_buffer
#(
  parameter WIDTH = `SAMPLE_WIDTH,
  parameter DEPTH = `BUF_DEPTH
)
(
  input  wire             clk_in,        // system clock
  input  wire             srst_in,       // sync reset, active high
  input  wire [WIDTH-1:0] in_data_in,    // word from source
  input  wire             in_valid_in,   // source offers a word
  output wire             in_ready_out,  // buffer has room
  output wire [WIDTH-1:0] out_data_out,  // oldest stored word
  output wire             out_valid_out, // buffer not empty
  input  wire             out_ready_in   // drain takes the word
);

  reg [WIDTH-1:0]                store_reg [0:DEPTH-1];
  reg [`BUF_PTR_WIDTH-1:0]       wr_ptr_reg;
  reg [`BUF_PTR_WIDTH-1:0]       rd_ptr_reg;
  reg [`BUF_CNT_WIDTH-1:0]       count_reg;
  wire                           push;
  wire                           pop;

  // honest full and empty
  assign in_ready_out  = (count_reg != DEPTH[`BUF_CNT_WIDTH-1:0]);
  assign out_valid_out = (count_reg != {`BUF_CNT_WIDTH{1'b0}});
  assign out_data_out  = store_reg[rd_ptr_reg];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // pointers and occupancy
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      wr_ptr_reg <= {`BUF_PTR_WIDTH{1'b0}};
      rd_ptr_reg <= {`BUF_PTR_WIDTH{1'b0}};
      count_reg  <= {`BUF_CNT_WIDTH{1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push & ~pop)
        count_reg <= count_reg + 1'b1;
      else if (pop & ~push)
        count_reg <= count_reg - 1'b1;
    end
  end

  // storage, no reset needed
  always @(posedge clk_in)
  begin
    if (push)
      store_reg[wr_ptr_reg] <= in_data_in;
  end

endmodule
